// ==== logic/bsbtw_pkg.sv ====
// Shared constants and carriers for the bit-skip, branch and table-write execution unit
package bsbtw_pkg;
    // ==========================================
    // Opcode fields
    localparam logic [3:0]  OP_SKIP_SET   = 4'ha;
    localparam logic [3:0]  OP_SKIP_CLR   = 4'hb;
    localparam logic [3:0]  OP_TOGGLE     = 4'h7;
    localparam logic [7:0]  OP_BRANCH_OV  = 8'he4;
    localparam logic [13:0] OP_TABLE_WR   = 14'h0003;
    localparam logic [1:0]  TW_PLAIN      = 2'h0;
    localparam logic [1:0]  TW_POST_INC   = 2'h1;
    localparam logic [1:0]  TW_POST_DEC   = 2'h2;
    localparam logic [1:0]  TW_PRE_INC    = 2'h3;
    localparam logic [3:0]  ACCESS_BANK   = 4'h0;
    localparam logic        ACC_USE_BANK  = 1'h1;
    localparam logic [20:0] TABLE_POINTER_RESET  = 21'h000000;
    localparam logic [20:0] PTR_STEP      = 21'h000001;
    localparam logic [20:0] PC_STEP       = 21'h000002;

    // ==========================================
    // Quarter phases and states
    typedef enum logic [3:0] {
        BSBTW_Q1 = 4'b0001,
        BSBTW_Q2 = 4'b0010,
        BSBTW_Q3 = 4'b0100,
        BSBTW_Q4 = 4'b1000
    } bsbtw_phase_e;

    typedef enum logic [3:0] {
        BSBTW_EXEC  = 4'b0001,
        BSBTW_FLUSH = 4'b0010,
        BSBTW_TWR2  = 4'b0100,
        BSBTW_IDLE  = 4'b1000
    } bsbtw_state_e;

    // ==========================================
    // Carriers
    typedef struct packed {
        logic        we;
        logic [11:0] addr;
        logic [7:0]  data;
    } bsbtw_dmem_wr_s;

    typedef struct packed {
        logic        we;
        logic [20:0] addr;
        logic [7:0]  data;
    } bsbtw_hold_wr_s;
endpackage

// ==== logic/bsbtw_qphase.sv ====
// Quarter-phase sequencer of the instruction cycle
`timescale 1ns/1ns
module bsbtw_qphase (
    input  wire logic                   clk_sys,
    input  wire logic                   rst_n,
    output bsbtw_pkg::bsbtw_phase_e     phase
);
    typedef struct packed {
        bsbtw_pkg::bsbtw_phase_e ph;
    } bsbtw_qstate_s;

    bsbtw_qstate_s st_ff;
    bsbtw_qstate_s nxt_st;

    // ==========================================
    // Phase rotation
    always_comb begin
        nxt_st = st_ff;
        unique case (st_ff.ph)
            bsbtw_pkg::BSBTW_Q1: nxt_st.ph = bsbtw_pkg::BSBTW_Q2;
            bsbtw_pkg::BSBTW_Q2: nxt_st.ph = bsbtw_pkg::BSBTW_Q3;
            bsbtw_pkg::BSBTW_Q3: nxt_st.ph = bsbtw_pkg::BSBTW_Q4;
            bsbtw_pkg::BSBTW_Q4: nxt_st.ph = bsbtw_pkg::BSBTW_Q1;
            default:             nxt_st.ph = bsbtw_pkg::BSBTW_Q1;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '{ph: bsbtw_pkg::BSBTW_Q1};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign phase = st_ff.ph;
endmodule

// ==== logic/bsbtw_exec.sv ====
// Execution of bit skip, bit toggle, overflow branch and table write instructions
// How it works
// - Skip-if-set skips the next instruction when the selected file bit is one.
// - A taken skip flushes the fetched word and runs one no-operation cycle.
// - Access flag zero addresses the access bank, ignoring the bank select register.
// - Access flag one takes the bank from the bank select register.
// - Toggle inverts only the selected bit, read-modify-write, one cycle, no flags.
// - Overflow branch is taken only when the overflow flag is one.
// - Branch target is incremented program counter plus twice the signed offset.
// - Taken branch takes two cycles, the second a no-operation; not taken one.
// - Plain table write copies the latch byte and leaves the pointer unchanged.
// - Mode field picks post-increment, post-decrement or pre-increment of the pointer.
`timescale 1ns/1ns
module bsbtw_exec (
    input  wire logic                        clk_sys,
    input  wire logic                        nrst,
    input  wire logic [15:0]                 instr_word,
    input  wire logic [20:0]                 instr_addr,
    input  wire logic [3:0]                  bank_select_register,
    input  wire logic                        ovf_flag,
    input  wire logic [7:0]                  dmem_rdata,
    input  wire logic [7:0]                  table_latch_byte,
    output logic                             instr_ack,
    output logic [11:0]                      dmem_addr,
    output bsbtw_pkg::bsbtw_dmem_wr_s        dmem_wr,
    output bsbtw_pkg::bsbtw_hold_wr_s        hold_wr,
    output logic [20:0]                      table_pointer,
    output logic                             pc_load,
    output logic [20:0]                      pc_target,
    output logic                             flush,
    output bsbtw_pkg::bsbtw_phase_e          phase,
    output bsbtw_pkg::bsbtw_state_e          exec_state
);
    typedef struct packed {
        bsbtw_pkg::bsbtw_state_e st;
        logic [15:0]             iw;
        logic [20:0]             ia;
        logic [7:0]              rd;
        logic [7:0]              lat;
        logic [20:0]             tp;
        logic [11:0]             dadr;
        bsbtw_pkg::bsbtw_dmem_wr_s dw;
        bsbtw_pkg::bsbtw_hold_wr_s hw;
        logic                    pcl;
        logic [20:0]             pct;
        logic                    fl;
        logic                    ack;
    } bsbtw_exec_s;

    bsbtw_exec_s st_ff;
    bsbtw_exec_s nxt_st;
    logic [1:0]  rst_sync_ff;
    logic [1:0]  nxt_rst_sync;
    logic        rst_n;
    logic        is_skip_set;
    logic        is_skip_clr;
    logic        is_toggle;
    logic        is_branch;
    logic        is_twr;
    logic [2:0]  bitsel;
    logic [7:0]  bitmask;
    logic [20:0] br_offset;

    // ==========================================
    // Reset release
    // Kept apart from the state struct: it has its own reset and clears the rest
    assign nxt_rst_sync = {rst_sync_ff[0], 1'b1};

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= nxt_rst_sync;
        end
    end
    assign rst_n = rst_sync_ff[1];

    bsbtw_qphase u_qphase (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .phase   (phase)
    );

    // ==========================================
    // Decode
    assign is_skip_set = st_ff.iw[15:12] == bsbtw_pkg::OP_SKIP_SET;
    assign is_skip_clr = st_ff.iw[15:12] == bsbtw_pkg::OP_SKIP_CLR;
    assign is_toggle   = st_ff.iw[15:12] == bsbtw_pkg::OP_TOGGLE;
    assign is_branch   = st_ff.iw[15:8] == bsbtw_pkg::OP_BRANCH_OV;
    assign is_twr      = st_ff.iw[15:2] == bsbtw_pkg::OP_TABLE_WR;
    assign bitsel      = st_ff.iw[11:9];
    assign bitmask     = 8'h01 << bitsel;
    assign br_offset   = {{12{st_ff.iw[7]}}, st_ff.iw[7:0], 1'b0};

    // ==========================================
    // Sequencing
    always_comb begin
        nxt_st = st_ff;
        nxt_st.dw.we = 1'b0;
        nxt_st.hw.we = 1'b0;
        nxt_st.pcl   = 1'b0;
        nxt_st.ack   = 1'b0;
        unique case (phase)
            bsbtw_pkg::BSBTW_Q1: begin
                if (st_ff.st == bsbtw_pkg::BSBTW_EXEC || st_ff.st == bsbtw_pkg::BSBTW_IDLE) begin
                    nxt_st.iw = instr_word;
                    nxt_st.ia = instr_addr;
                    nxt_st.fl = 1'b0;
                    nxt_st.st = bsbtw_pkg::BSBTW_EXEC;
                    if (instr_word[8] == bsbtw_pkg::ACC_USE_BANK) begin
                        nxt_st.dadr = {bank_select_register, instr_word[7:0]};
                    end else begin
                        nxt_st.dadr = {bsbtw_pkg::ACCESS_BANK, instr_word[7:0]};
                    end
                end
            end
            bsbtw_pkg::BSBTW_Q2: begin
                nxt_st.rd = dmem_rdata;
                if (st_ff.st == bsbtw_pkg::BSBTW_TWR2) begin
                    nxt_st.lat = table_latch_byte;
                end
            end
            bsbtw_pkg::BSBTW_Q3: begin
                if (st_ff.st == bsbtw_pkg::BSBTW_EXEC && is_twr && st_ff.iw[1:0] == bsbtw_pkg::TW_PRE_INC) begin
                    nxt_st.tp = st_ff.tp + bsbtw_pkg::PTR_STEP;
                end
            end
            bsbtw_pkg::BSBTW_Q4: begin
                nxt_st.ack = 1'b1;
                nxt_st.fl  = 1'b0;
                nxt_st.st  = bsbtw_pkg::BSBTW_EXEC;
                if (st_ff.st == bsbtw_pkg::BSBTW_EXEC) begin
                    if ((is_skip_set && (st_ff.rd & bitmask) != 8'h00) ||
                        (is_skip_clr && (st_ff.rd & bitmask) == 8'h00)) begin
                        nxt_st.st = bsbtw_pkg::BSBTW_FLUSH;
                        nxt_st.fl = 1'b1;
                    end
                    if (is_toggle) begin
                        nxt_st.dw = '{we: 1'b1, addr: st_ff.dadr, data: st_ff.rd ^ bitmask};
                    end
                    if (is_branch && ovf_flag) begin
                        nxt_st.pcl = 1'b1;
                        nxt_st.pct = st_ff.ia + bsbtw_pkg::PC_STEP + br_offset;
                        nxt_st.st  = bsbtw_pkg::BSBTW_FLUSH;
                        nxt_st.fl  = 1'b1;
                    end
                    if (is_twr) begin
                        nxt_st.st  = bsbtw_pkg::BSBTW_TWR2;
                        nxt_st.ack = 1'b0;
                    end
                end else if (st_ff.st == bsbtw_pkg::BSBTW_TWR2) begin
                    nxt_st.hw = '{we: 1'b1, addr: st_ff.tp, data: st_ff.lat};
                    unique case (st_ff.iw[1:0])
                        bsbtw_pkg::TW_POST_INC: nxt_st.tp = st_ff.tp + bsbtw_pkg::PTR_STEP;
                        bsbtw_pkg::TW_POST_DEC: nxt_st.tp = st_ff.tp - bsbtw_pkg::PTR_STEP;
                        bsbtw_pkg::TW_PLAIN:    nxt_st.tp = st_ff.tp;
                        bsbtw_pkg::TW_PRE_INC:  nxt_st.tp = st_ff.tp;
                    endcase
                end
            end
            default: begin
                nxt_st.st = bsbtw_pkg::BSBTW_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_ff.st   <= bsbtw_pkg::BSBTW_IDLE;
            st_ff.iw   <= 16'h0000;
            st_ff.ia   <= 21'h000000;
            st_ff.rd   <= 8'h00;
            st_ff.lat  <= 8'h00;
            st_ff.tp   <= bsbtw_pkg::TABLE_POINTER_RESET;
            st_ff.dadr <= 12'h000;
            st_ff.dw   <= '0;
            st_ff.hw   <= '0;
            st_ff.pcl  <= 1'b0;
            st_ff.pct  <= 21'h000000;
            st_ff.fl   <= 1'b0;
            st_ff.ack  <= 1'b0;
        end else begin
            st_ff.st   <= nxt_st.st;
            st_ff.iw   <= nxt_st.iw;
            st_ff.ia   <= nxt_st.ia;
            st_ff.rd   <= nxt_st.rd;
            st_ff.lat  <= nxt_st.lat;
            st_ff.tp   <= nxt_st.tp;
            st_ff.dadr <= nxt_st.dadr;
            st_ff.dw   <= nxt_st.dw;
            st_ff.hw   <= nxt_st.hw;
            st_ff.pcl  <= nxt_st.pcl;
            st_ff.pct  <= nxt_st.pct;
            st_ff.fl   <= nxt_st.fl;
            st_ff.ack  <= nxt_st.ack;
        end
    end

    // ==========================================
    // Outputs
    assign instr_ack     = st_ff.ack;
    assign dmem_addr     = st_ff.dadr;
    assign dmem_wr       = st_ff.dw;
    assign hold_wr       = st_ff.hw;
    assign table_pointer = st_ff.tp;
    assign pc_load       = st_ff.pcl;
    assign pc_target     = st_ff.pct;
    assign flush         = st_ff.fl;
    assign exec_state    = st_ff.st;
endmodule

// ==== tb/bsbtw_exec_assertions.sv ====
// Concurrent checks on the execution unit ports
`timescale 1ns/1ns
module bsbtw_exec_chk (
    input wire logic                       clk_sys,
    input wire logic                       nrst,
    input wire logic [15:0]                instr_word,
    input wire logic [20:0]                instr_addr,
    input wire logic [3:0]                 bank_select_register,
    input wire logic                       ovf_flag,
    input wire logic [7:0]                 dmem_rdata,
    input wire logic [7:0]                 table_latch_byte,
    input wire bsbtw_pkg::bsbtw_dmem_wr_s  dmem_wr,
    input wire bsbtw_pkg::bsbtw_hold_wr_s  hold_wr,
    input wire logic                       pc_load,
    input wire logic [20:0]                pc_target,
    input wire logic                       flush,
    input wire bsbtw_pkg::bsbtw_state_e    exec_state
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // ==========================================
    // Properties
    property p_we_pulse;
        dmem_wr.we |=> !dmem_wr.we;
    endproperty
    a_we_pulse: assert property (p_we_pulse) else $error("write pulse too long");
    property p_toggle_data;
        dmem_wr.we |-> dmem_wr.data == ($past(dmem_rdata, 3) ^ (8'h01 << $past(instr_word[11:9], 4)));
    endproperty
    a_toggle_data: assert property (p_toggle_data) else $error("toggle data wrong");
    property p_toggle_bank;
        dmem_wr.we |-> dmem_wr.addr[11:8] ==
            ($past(instr_word[8], 4) ? $past(bank_select_register, 4) : bsbtw_pkg::ACCESS_BANK);
    endproperty
    a_toggle_bank: assert property (p_toggle_bank) else $error("bank wrong");
    property p_branch_target;
        pc_load |-> pc_target == $past(instr_addr, 4) + bsbtw_pkg::PC_STEP
            + {{12{$past(instr_word[7], 4)}}, $past(instr_word[7:0], 4), 1'b0};
    endproperty
    a_branch_target: assert property (p_branch_target) else $error("branch target wrong");
    property p_branch_ovf;
        pc_load |-> $past(ovf_flag);
    endproperty
    a_branch_ovf: assert property (p_branch_ovf) else $error("branch without overflow");
    property p_branch_nop;
        pc_load |-> flush [*4] ##1 !flush;
    endproperty
    a_branch_nop: assert property (p_branch_nop) else $error("no-operation cycle wrong");
    property p_hold_data;
        hold_wr.we |-> hold_wr.data == $past(table_latch_byte, 3);
    endproperty
    a_hold_data: assert property (p_hold_data) else $error("holding data wrong");
    property p_hold_cycle;
        hold_wr.we |-> $past(exec_state) == bsbtw_pkg::BSBTW_TWR2;
    endproperty
    a_hold_cycle: assert property (p_hold_cycle) else $error("holding write early");
    c_toggle: cover property (dmem_wr.we);
    c_branch: cover property (pc_load);
    c_hold: cover property (hold_wr.we);
endmodule
bind bsbtw_exec bsbtw_exec_chk u_chk (.*);

// ==== tb/testbench.sv ====
// Random and corner-case bench for the execution unit
`timescale 1ns/1ns
module testbench;
    logic                      clk_sys = 0;
    logic                      nrst = 0;
    logic [15:0]               instr_word = '0;
    logic [20:0]               instr_addr = '0;
    logic [3:0]                bank_select_register = '0;
    logic                      ovf_flag = 0;
    logic [7:0]                dmem_rdata = '0;
    logic [7:0]                table_latch_byte = '0;
    logic                      instr_ack, pc_load, flush;
    logic [11:0]               dmem_addr;
    logic [20:0]               table_pointer, pc_target;
    logic [20:0]               ptr = bsbtw_pkg::TABLE_POINTER_RESET;
    bsbtw_pkg::bsbtw_dmem_wr_s dmem_wr;
    bsbtw_pkg::bsbtw_hold_wr_s hold_wr;
    bsbtw_pkg::bsbtw_phase_e   phase;
    bsbtw_pkg::bsbtw_state_e   exec_state;
    int                        miscompares = 0;
    int                        total_checks = 0;
    always #20 clk_sys = ~clk_sys;
    bsbtw_exec DUT (.clk_sys(clk_sys), .nrst(nrst), .instr_word(instr_word), .instr_addr(instr_addr),
        .bank_select_register(bank_select_register), .ovf_flag(ovf_flag), .dmem_rdata(dmem_rdata),
        .table_latch_byte(table_latch_byte), .instr_ack(instr_ack), .dmem_addr(dmem_addr),
        .dmem_wr(dmem_wr), .hold_wr(hold_wr), .table_pointer(table_pointer), .pc_load(pc_load),
        .pc_target(pc_target), .flush(flush), .phase(phase), .exec_state(exec_state));
    // ==========================================
    // Helpers
    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    function automatic logic [20:0] tgt(logic [20:0] a, logic [7:0] n);
        return a + bsbtw_pkg::PC_STEP + {{12{n[7]}}, n, 1'b0};
    endfunction
    function automatic logic exp_flush(logic [15:0] w, logic [7:0] r, logic o);
        if (w[15:12] == bsbtw_pkg::OP_SKIP_SET) return r[w[11:9]];
        if (w[15:12] == bsbtw_pkg::OP_SKIP_CLR) return !r[w[11:9]];
        return (w[15:8] == bsbtw_pkg::OP_BRANCH_OV) && o;
    endfunction
    // ==========================================
    // One instruction cycle with its checks
    task automatic run(logic [15:0] w, logic o);
        logic [7:0]  r;
        logic [3:0]  b;
        logic [20:0] a;
        logic        tw;
        logic        br;
        r = 8'($urandom);
        b = 4'($urandom);
        a = 21'($urandom);
        tw = w[15:2] == bsbtw_pkg::OP_TABLE_WR;
        br = w[15:8] == bsbtw_pkg::OP_BRANCH_OV;
        do begin
            @(posedge clk_sys);
            #1;
        end while (phase !== bsbtw_pkg::BSBTW_Q1 || exec_state[1] !== 1'b0 || exec_state[2] !== 1'b0);
        instr_word = w;
        instr_addr = a;
        bank_select_register = b;
        ovf_flag = o;
        dmem_rdata = r;
        table_latch_byte = 8'($urandom);
        repeat (4) @(posedge clk_sys);
        #1;
        check("we", dmem_wr.we, w[15:12] == bsbtw_pkg::OP_TOGGLE);
        if (dmem_wr.we === 1'b1) begin
            check("wdata", dmem_wr.data, r ^ (8'h01 << w[11:9]));
            check("waddr", dmem_wr.addr, {w[8] ? b : bsbtw_pkg::ACCESS_BANK, w[7:0]});
        end
        check("pcload", pc_load, br && o);
        if (br && o) check("target", pc_target, tgt(a, w[7:0]));
        check("flush", flush, exp_flush(w, r, o));
        check("ack", instr_ack, !tw);
        check("daddr", dmem_addr, {w[8] ? b : bsbtw_pkg::ACCESS_BANK, w[7:0]});
        if (exp_flush(w, r, o)) begin
            instr_word = {bsbtw_pkg::OP_TOGGLE, 12'h1ff};
            repeat (4) @(posedge clk_sys);
            #1;
            check("refused", dmem_wr.we, 0);
        end
        if (tw) begin
            check("ack1", instr_ack, 0);
            repeat (4) @(posedge clk_sys);
            #1;
            check("hwe", hold_wr.we, 1);
            check("haddr", hold_wr.addr, w[1:0] == bsbtw_pkg::TW_PRE_INC ? 21'(ptr + bsbtw_pkg::PTR_STEP) : ptr);
            check("hdata", hold_wr.data, table_latch_byte);
            if (w[1:0] == bsbtw_pkg::TW_POST_DEC) ptr = ptr - bsbtw_pkg::PTR_STEP;
            else if (w[1:0] != bsbtw_pkg::TW_PLAIN) ptr = ptr + bsbtw_pkg::PTR_STEP;
            check("ptr", table_pointer, ptr);
        end
        instr_word = '0;
    endtask
    initial begin
        void'($urandom(64));
        repeat (2) @(posedge clk_sys);
        #1;
        nrst = 1;
        repeat (2) @(posedge clk_sys);
        run({bsbtw_pkg::OP_TOGGLE, 4'he, 8'h3c}, 0);
        run({bsbtw_pkg::OP_BRANCH_OV, 8'h80}, 1);
        run({bsbtw_pkg::OP_BRANCH_OV, 8'h7f}, 1);
        run({bsbtw_pkg::OP_BRANCH_OV, 8'h10}, 0);
        for (int m = 0; m < 4; m++) run({bsbtw_pkg::OP_TABLE_WR, 2'(m)}, 0);
        for (int i = 0; i < 80; i++) begin
            case ($urandom % 5)
                0: run({bsbtw_pkg::OP_SKIP_SET, 12'($urandom)}, 1'($urandom));
                1: run({bsbtw_pkg::OP_SKIP_CLR, 12'($urandom)}, 1'($urandom));
                2: run({bsbtw_pkg::OP_TOGGLE, 12'($urandom)}, 1'($urandom));
                3: run({bsbtw_pkg::OP_BRANCH_OV, 8'($urandom)}, 1'($urandom));
                default: run({bsbtw_pkg::OP_TABLE_WR, 2'($urandom)}, 1'($urandom));
            endcase
        end
        conclude();
    end
    initial begin
        #600000;
        miscompares++;
        conclude();
    end
endmodule
